// ### dv/tco_pin_model.sv
`timescale 1ns/1ns
module tco_pin_model (
  input wire logic clk_i,
  input wire logic fire_i,
  output logic pin_o
);
  logic [4:0] cnt_q = 5'h00;
  // One request gives 16 high then 15 low cycles, long enough for the filter
  always_ff @(posedge clk_i)
  begin
    if (fire_i && cnt_q == 5'h00)
      cnt_q <= 5'h1f;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
  end
  assign pin_o = cnt_q[4];
endmodule : tco_pin_model

// ### dv/tco_timer_asserts.sv
`timescale 1ns/1ns
module tco_timer_asserts (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_mode_i,
  input wire logic timer_interrupt_request_o,
  input wire logic timer_ff_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [7:0] ctrl_q;
  logic stop_q;
  logic [1:0] quiet_q;
  // Access decode and control shadow triggers
  wire acc = psel && penable;
  wire mapped = paddr inside {8'h40, 8'h44, 8'h48, 8'h4c, 8'h98, 8'h9c};
  wire unmapped = paddr[1:0] == 2'h0 && !mapped;
  wire ctrl_wr = acc && pwrite && paddr == 8'h98;
  wire stop_rise = stop_mode_i && !stop_q;
  wire idle = quiet_q == 2'h3 && ctrl_q[5:4] == 2'h0;
  // Stop entry wins over a write; quiet counts settled cycles
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ctrl_q <= 8'h00;
      stop_q <= 1'b0;
      quiet_q <= 2'h0;
    end
    else
    begin
      stop_q <= stop_mode_i;
      if (stop_rise)
        ctrl_q <= {ctrl_q[7:6], 2'h0, ctrl_q[3:0]};
      else if (ctrl_wr)
        ctrl_q <= pwdata[7:0];
      quiet_q <= (stop_rise || ctrl_wr) ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
    end
  end
  chk_ready_now: assert property (pready == acc)
    else $error("pready not tied to access phase");
  chk_err_unmapped: assert property (acc && unmapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_upper_zero: assert property (acc && !pwrite && mapped && paddr != 8'h9c |-> prdata[31:8] == 24'h0)
    else $error("byte register upper bits set");
  chk_irq_single: assert property ($rose(timer_interrupt_request_o) |=> !timer_interrupt_request_o)
    else $error("request longer than one cycle");
  chk_stop_silent: assert property (idle |-> !timer_interrupt_request_o)
    else $error("request while stopped");
  chk_ff_preset: assert property (idle |-> timer_ff_o == ctrl_q[7])
    else $error("flip-flop not preset");
  chk_ctrl_back: assert property (acc && !pwrite && paddr == 8'h98 && quiet_q == 2'h3 |-> prdata[7:0] == ctrl_q)
    else $error("control readback wrong");
endmodule : tco_timer_asserts

// ### dv/tco_timer_tb_top.sv
`timescale 1ns/1ns
`include "tco_defines.svh"
module tco_timer_tb_top;
  logic clk_i = 1'b0, srst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, pin, irq, ff, opt = 1'b0, slow = 1'b0, stop = 1'b0, fire = 1'b0;
  logic [2:0] fs_q = 3'h0;
  int miscompares = 0, comparisons = 0;
  logic [3:0] cfg [4] = '{4'h2, 4'h1, 4'h4, 4'h8};
  int shf [4] = '{3, 7, 6, 6};
  always #20 clk_i = ~clk_i;
  // Slow clock at one eighth of the bus clock
  always @(posedge clk_i) fs_q <= fs_q + 3'h1;
  tco_timer tco_timer_i (.clk_i(clk_i), .srst_i(srst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_pin_i(pin), .low_clk_i(fs_q[2]),
    .low_freq_divider_option_i(opt), .slow_mode_i(slow), .stop_mode_i(stop),
    .timer_interrupt_request_o(irq), .timer_ff_o(ff));
  tco_pin_model tco_pin_model_i (.clk_i(clk_i), .fire_i(fire), .pin_o(pin));
  task automatic fail(input string m);
    miscompares++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask : chk
  // Setup, then hold until pready is seen at an edge; one idle cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge clk_i);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask : rd
  // Cycles between two requests
  task automatic period(input int exp);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    n = 1;
    while (irq !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n, exp);
  endtask : period
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // Runaway guard, far above the expected few thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk_i);
    fail("watchdog");
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`TCO_ADDR_A_LO, 32'hff);
    rd(`TCO_ADDR_A_HI, 32'hff);
    rd(`TCO_ADDR_B_LO, 32'hff);
    rd(`TCO_ADDR_CTRL, 32'h00);
    apb(1'b1, 8'h00, 8'h5a);
    chk({31'h0, rerr}, 32'h1);
    rd(8'h00, 32'h0);
    $display("test reset done");
    apb(1'b1, `TCO_ADDR_CTRL, 8'h08);
    apb(1'b1, `TCO_ADDR_A_LO, 8'h04);
    repeat (40) @(posedge clk_i);
    rd(`TCO_ADDR_A_LO, 32'hff);
    apb(1'b1, `TCO_ADDR_A_HI, 8'h00);
    repeat (20) @(posedge clk_i);
    rd(`TCO_ADDR_A_LO, 32'h04);
    apb(1'b1, `TCO_ADDR_B_LO, 8'h12);
    apb(1'b1, `TCO_ADDR_B_HI, 8'h34);
    repeat (20) @(posedge clk_i);
    rd(`TCO_ADDR_B_LO, 32'hff);
    apb(1'b1, `TCO_ADDR_CTRL, 8'h0b);
    apb(1'b1, `TCO_ADDR_B_LO, 8'h12);
    apb(1'b1, `TCO_ADDR_B_HI, 8'h34);
    repeat (20) @(posedge clk_i);
    rd(`TCO_ADDR_B_HI, 32'h34);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      opt <= cfg[i][2];
      slow <= cfg[i][3];
      apb(1'b1, `TCO_ADDR_CTRL, {4'h0, cfg[i][1:0], 2'h0});
      apb(1'b1, `TCO_ADDR_CTRL, {4'h1, cfg[i][1:0], 2'h0});
      period(4 << shf[i]);
      apb(1'b1, `TCO_ADDR_CTRL, 8'h00);
      rd(`TCO_ADDR_COUNT, 32'h0);
    end
    opt <= 1'b0;
    slow <= 1'b0;
    $display("test timer done");
    apb(1'b1, `TCO_ADDR_CTRL, 8'h18);
    repeat (10) @(posedge clk_i);
    stop <= 1'b1;
    repeat (4) @(posedge clk_i);
    stop <= 1'b0;
    rd(`TCO_ADDR_CTRL, 32'h08);
    rd(`TCO_ADDR_COUNT, 32'h0);
    apb(1'b1, `TCO_ADDR_CTRL, 8'h80);
    repeat (3) @(posedge clk_i);
    chk({31'h0, ff}, 32'h1);
    apb(1'b1, `TCO_ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({31'h0, ff}, 32'h0);
    $display("test stop done");
    // Rising code counts early in the pulse, falling code only after it
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, `TCO_ADDR_CTRL, 8'h0c);
      apb(1'b1, `TCO_ADDR_CTRL, {2'h0, 2'h2 + 2'(i), 4'hc});
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(`TCO_ADDR_COUNT, 32'(1 - i));
      repeat (40) @(posedge clk_i);
      rd(`TCO_ADDR_COUNT, 32'h1);
    end
    $display("test event done");
    // Trigger start; with bit 6 set the falling edge halts and clears early
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, `TCO_ADDR_CTRL, 8'h08);
      apb(1'b1, `TCO_ADDR_CTRL, {1'b0, 1'(i), 6'h28});
      repeat (16) @(posedge clk_i);
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (20) @(posedge clk_i);
      apb(1'b0, `TCO_ADDR_COUNT, 8'h00);
      chk({31'h0, rdat[15:0] == 16'h0000}, 32'(i));
    end
    $display("test trigger done");
    // Auto-capture overwrites the generator value left in register B
    apb(1'b1, `TCO_ADDR_CTRL, 8'h08);
    apb(1'b1, `TCO_ADDR_CTRL, 8'h58);
    repeat (20) @(posedge clk_i);
    rd(`TCO_ADDR_B_HI, 32'h0);
    apb(1'b1, `TCO_ADDR_CTRL, 8'h00);
    $display("test capture done");
    print_verdict();
  end
endmodule : tco_timer_tb_top
bind tco_timer tco_timer_asserts tco_timer_asserts_i (.clk_i(clk_i), .srst_i(srst_i),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode_i(stop_mode_i),
  .timer_interrupt_request_o(timer_interrupt_request_o), .timer_ff_o(timer_ff_o));

// ### hdl/tco_tick_gen.sv
`timescale 1ns/1ns
`include "tco_defines.svh"

module tco_tick_gen #(
  parameter int DIV_W = 11
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] clk_sel_i,
  input wire logic low_freq_i,
  input wire logic fs_clk_i,
  input wire logic ext_edge_i,
  output logic src_tick_o
);

  if (DIV_W < `TCO_TAP_SLOW) begin : g_chk
    $error("tco_tick_gen: DIV_W too small for the slowest tap");
  end

  logic [DIV_W-1:0] div_q;
  logic fs_s1_q;
  logic fs_s2_q;
  logic fs_d_q;
  logic [`TCO_FS_DIV_W-1:0] fs_div_q;
  logic tick_q;
  logic fs_rise;
  logic fs_tick;
  logic tap_slow;
  logic tap_mid;
  logic tap_fast;
  logic tick_d;

  // Taps pulse once per 2^n cycles, when the low n bits are all ones
  assign tap_slow = &div_q[`TCO_TAP_SLOW-1:0];
  assign tap_mid = &div_q[`TCO_TAP_MID-1:0];
  assign tap_fast = &div_q[`TCO_TAP_FAST-1:0];
  assign fs_rise = fs_s2_q & ~fs_d_q;
  assign fs_tick = fs_rise & (&fs_div_q);

  // Source clock choice; low-frequency path replaces only the slow tap
  assign tick_d = (clk_sel_i == tco_pkg::TCO_CK_EXT) ? ext_edge_i :
                  (clk_sel_i == tco_pkg::TCO_CK_FAST) ? tap_fast :
                  (clk_sel_i == tco_pkg::TCO_CK_MID) ? tap_mid :
                  (low_freq_i ? fs_tick : tap_slow);

  // Free divider, low clock synchroniser and output register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      div_q <= '0;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
      fs_d_q <= 1'b0;
      fs_div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 1'b1;
      fs_s1_q <= fs_clk_i;
      fs_s2_q <= fs_s1_q;
      fs_d_q <= fs_s2_q;
      if (fs_rise)
        fs_div_q <= fs_div_q + 1'b1;
      tick_q <= tick_d;
    end
  end

  assign src_tick_o = tick_q;

endmodule : tco_tick_gen

// ### hdl/tco_timer.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "tco_defines.svh"

module tco_timer #(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin_i,
  input wire logic low_clk_i,
  input wire logic low_freq_divider_option_i,
  input wire logic slow_mode_i,
  input wire logic stop_mode_i,
  output logic timer_interrupt_request_o,
  output logic timer_ff_o
);

  if (CNT_W != 16) begin : g_chk
    $error("tco_timer: register map serves a 16-bit counter only");
  end

  tco_pkg::tco_state_t state_q;
  tco_pkg::tco_state_t state_d;
  logic [7:0] ctrl_q;
  logic [15:0] a_q;
  logic [15:0] a_stage_q;
  logic [7:0] a_lo_q;
  logic a_pend_q;
  logic [15:0] b_q;
  logic [15:0] b_stage_q;
  logic [7:0] b_lo_q;
  logic b_pend_q;
  logic [15:0] cnt_q;
  logic ff_q;
  logic irq_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_d_q;
  logic stop_d_q;
  logic [31:0] prdata_q;
  logic err_q;

  // Control fields, declared ahead of the decode that reads the mode
  tco_pkg::tco_mode_t mode;
  tco_pkg::tco_start_t ss;
  tco_pkg::tco_clk_t ck;
  logic bit6;
  assign mode = tco_pkg::tco_mode_t'(ctrl_q[`TCO_MD_HI:`TCO_MD_LO]);
  assign ss = tco_pkg::tco_start_t'(ctrl_q[`TCO_SS_HI:`TCO_SS_LO]);
  assign ck = tco_pkg::tco_clk_t'(ctrl_q[`TCO_CK_HI:`TCO_CK_LO]);
  assign bit6 = ctrl_q[`TCO_B6_BIT];

  // Bus decode
  logic setup;
  logic wr;
  logic hit;
  logic wr_a_lo;
  logic wr_a_hi;
  logic wr_b_lo;
  logic wr_b_hi;
  logic wr_ctrl;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign wbyte = pwdata[7:0];
  assign hit = (paddr == `TCO_ADDR_A_LO) | (paddr == `TCO_ADDR_A_HI) |
               (paddr == `TCO_ADDR_B_LO) | (paddr == `TCO_ADDR_B_HI) |
               (paddr == `TCO_ADDR_CTRL) | (paddr == `TCO_ADDR_COUNT);
  assign wr_a_lo = wr & (paddr == `TCO_ADDR_A_LO);
  assign wr_a_hi = wr & (paddr == `TCO_ADDR_A_HI);
  assign wr_b_lo = wr & (paddr == `TCO_ADDR_B_LO) & (mode == tco_pkg::TCO_MD_PPG);
  assign wr_b_hi = wr & (paddr == `TCO_ADDR_B_HI) & (mode == tco_pkg::TCO_MD_PPG);
  assign wr_ctrl = wr & (paddr == `TCO_ADDR_CTRL);
  // Reads show effective values; count is read-only
  assign rd_mux = (paddr == `TCO_ADDR_A_LO) ? {24'h000000, a_q[7:0]} :
                  (paddr == `TCO_ADDR_A_HI) ? {24'h000000, a_q[15:8]} :
                  (paddr == `TCO_ADDR_B_LO) ? {24'h000000, b_q[7:0]} :
                  (paddr == `TCO_ADDR_B_HI) ? {24'h000000, b_q[15:8]} :
                  (paddr == `TCO_ADDR_CTRL) ? {24'h000000, ctrl_q} :
                  (paddr == `TCO_ADDR_COUNT) ? {16'h0000, cnt_q} : 32'h00000000;

  // Mode flavours inside code 00, told apart by start and clock
  logic grp0;
  logic is_event;
  logic is_trig;
  logic is_plain;
  assign grp0 = (mode == tco_pkg::TCO_MD_TIMER);
  assign is_event = grp0 & (ck == tco_pkg::TCO_CK_EXT) & ss[1];
  assign is_trig = grp0 & (ck != tco_pkg::TCO_CK_EXT) & ss[1];
  assign is_plain = grp0 & (ss == tco_pkg::TCO_SS_CMD);

  // Pin edges; code 11 triggers on falling, code 10 on rising
  logic rise;
  logic fall;
  logic trig_edge;
  logic opp_edge;
  logic level_ok;
  assign rise = pin_s2_q & ~pin_d_q;
  assign fall = ~pin_s2_q & pin_d_q;
  assign trig_edge = ss[0] ? fall : rise;
  assign opp_edge = ss[0] ? rise : fall;
  assign level_ok = ss[0] ? ~pin_s2_q : pin_s2_q;

  logic tick;
  tco_tick_gen #(
    .DIV_W(`TCO_TAP_SLOW)
  ) u_tick (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clk_sel_i(ctrl_q[`TCO_CK_HI:`TCO_CK_LO]),
    .low_freq_i(low_freq_divider_option_i | slow_mode_i),
    .fs_clk_i(low_clk_i),
    .ext_edge_i(trig_edge),
    .src_tick_o(tick)
  );

  // Start decisions; command start only for plain timer and generator
  logic start_cmd;
  logic free_run;
  logic arm;
  assign start_cmd = (ss == tco_pkg::TCO_SS_CMD) &
                     ((grp0 & (ck != tco_pkg::TCO_CK_EXT)) |
                      (mode == tco_pkg::TCO_MD_PPG));
  assign free_run = is_event | ((mode == tco_pkg::TCO_MD_WINDOW) & ss[1]);
  assign arm = ss[1] & ~free_run;

  // Counting and events while running
  logic running;
  logic cnt_en;
  logic [15:0] cnt_inc;
  logic match_a;
  logic match_b;
  logic trig_stop;
  logic pw_cap;
  logic auto_cap;
  assign running = (state_q == tco_pkg::TCO_ST_RUN);
  assign cnt_en = running & tick &
                  ((mode != tco_pkg::TCO_MD_WINDOW) | level_ok);
  assign cnt_inc = cnt_q + 16'h0001;
  assign match_a = cnt_en & (cnt_inc == a_q) & (mode != tco_pkg::TCO_MD_PULSE);
  assign match_b = cnt_en & (cnt_inc == b_q) & (mode == tco_pkg::TCO_MD_PPG);
  assign trig_stop = running & is_trig & bit6 & opp_edge;
  assign pw_cap = running & (mode == tco_pkg::TCO_MD_PULSE) &
                  (bit6 ? trig_edge : opp_edge);
  assign auto_cap = running & tick & bit6 &
                    (is_plain | is_event | (mode == tco_pkg::TCO_MD_WINDOW));
  // Halting matches return to armed and wait for the next trigger
  logic halt_match;
  assign halt_match = match_a & (is_trig |
                      ((mode == tco_pkg::TCO_MD_PPG) & bit6));

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      tco_pkg::TCO_ST_STOP:
      begin
        if (start_cmd | free_run)
          state_d = tco_pkg::TCO_ST_RUN;
        else if (arm)
          state_d = tco_pkg::TCO_ST_ARMED;
      end
      tco_pkg::TCO_ST_ARMED:
      begin
        if (trig_edge)
          state_d = tco_pkg::TCO_ST_RUN;
      end
      tco_pkg::TCO_ST_RUN:
      begin
        if (halt_match | trig_stop)
          state_d = tco_pkg::TCO_ST_ARMED;
        else if (pw_cap & ~bit6)
          state_d = tco_pkg::TCO_ST_ARMED;
      end
      default:
        state_d = tco_pkg::TCO_ST_STOP;
    endcase
    if (ss == tco_pkg::TCO_SS_STOP)
      state_d = tco_pkg::TCO_ST_STOP;
  end

  // State and counter
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q <= tco_pkg::TCO_ST_STOP;
      cnt_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      if (!running | match_a | trig_stop | pw_cap)
        cnt_q <= 16'h0000;
      else if (cnt_en)
        cnt_q <= cnt_inc;
    end
  end

  // Control register; stop-mode entry overrides a same-cycle write
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ctrl_q <= `TCO_RST_CTRL;
    else if (stop_mode_i & ~stop_d_q)
      ctrl_q[`TCO_SS_HI:`TCO_SS_LO] <= tco_pkg::TCO_SS_STOP;
    else if (wr_ctrl)
      ctrl_q <= wbyte;
  end

  // Register A: low byte staged, high byte arms update at next tick
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      a_q <= `TCO_RST_A;
      a_stage_q <= `TCO_RST_A;
      a_lo_q <= 8'h00;
      a_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_a_lo)
        a_lo_q <= wbyte;
      if (wr_a_hi)
      begin
        a_stage_q <= {wbyte, a_lo_q};
        a_pend_q <= 1'b1;
      end
      else if (tick & a_pend_q)
      begin
        a_q <= a_stage_q;
        a_pend_q <= 1'b0;
      end
    end
  end

  // Register B: software load or hardware capture
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      b_q <= `TCO_RST_B;
      b_stage_q <= `TCO_RST_B;
      b_lo_q <= 8'h00;
      b_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_b_lo)
        b_lo_q <= wbyte;
      if (wr_b_hi)
      begin
        b_stage_q <= {wbyte, b_lo_q};
        b_pend_q <= 1'b1;
      end
      else if (tick & b_pend_q)
      begin
        b_q <= b_stage_q;
        b_pend_q <= 1'b0;
      end
      else if (pw_cap)
        b_q <= cnt_q;
      else if (auto_cap)
        b_q <= cnt_q;
    end
  end

  // Timer flip-flop: preset while stopped, toggled by a match of A or of B alone
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ff_q <= 1'b0;
    else if (state_q == tco_pkg::TCO_ST_STOP)
      ff_q <= ctrl_q[`TCO_FF_BIT];
    else if (match_a ^ match_b)
      ff_q <= ~ff_q;
  end

  // Pin synchroniser, stop edge detect and request pulse
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_d_q <= 1'b0;
      stop_d_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= timer_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_d_q <= pin_s2_q;
      stop_d_q <= stop_mode_i;
      irq_q <= match_a | pw_cap;
    end
  end

  // Read data and error latched in setup so access needs no wait
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= rd_mux;
      err_q <= ~hit;
    end
  end

  assign prdata = prdata_q;
  assign pready = psel & penable;
  assign pslverr = psel & penable & err_q;
  assign timer_interrupt_request_o = irq_q;
  assign timer_ff_o = ff_q;

endmodule : tco_timer

// ### pkg/tco_defines.svh
`ifndef TCO_DEFINES_SVH
`define TCO_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define TCO_IDX_A_LO 6'h10
`define TCO_IDX_A_HI 6'h11
`define TCO_IDX_B_LO 6'h12
`define TCO_IDX_B_HI 6'h13
`define TCO_IDX_CTRL 6'h26
`define TCO_IDX_COUNT 6'h27
`define TCO_ADDR_A_LO {`TCO_IDX_A_LO, 2'b00}
`define TCO_ADDR_A_HI {`TCO_IDX_A_HI, 2'b00}
`define TCO_ADDR_B_LO {`TCO_IDX_B_LO, 2'b00}
`define TCO_ADDR_B_HI {`TCO_IDX_B_HI, 2'b00}
`define TCO_ADDR_CTRL {`TCO_IDX_CTRL, 2'b00}
`define TCO_ADDR_COUNT {`TCO_IDX_COUNT, 2'b00}

// Reset values
`define TCO_RST_A 16'hffff
`define TCO_RST_B 16'hffff
`define TCO_RST_CTRL 8'h00

// Control register field positions
`define TCO_FF_BIT 7
`define TCO_B6_BIT 6
`define TCO_SS_HI 5
`define TCO_SS_LO 4
`define TCO_CK_HI 3
`define TCO_CK_LO 2
`define TCO_MD_HI 1
`define TCO_MD_LO 0

// Prescaler tap exponents and low-frequency divide
`define TCO_TAP_SLOW 11
`define TCO_TAP_MID 7
`define TCO_TAP_FAST 3
`define TCO_FS_DIV_W 3

`endif

// ### pkg/tco_pkg.sv
package tco_pkg;

  typedef enum logic [1:0] {
    TCO_MD_TIMER = 2'h0,
    TCO_MD_WINDOW = 2'h1,
    TCO_MD_PULSE = 2'h2,
    TCO_MD_PPG = 2'h3
  } tco_mode_t;

  typedef enum logic [1:0] {
    TCO_SS_STOP = 2'h0,
    TCO_SS_CMD = 2'h1,
    TCO_SS_RISE = 2'h2,
    TCO_SS_FALL = 2'h3
  } tco_start_t;

  typedef enum logic [1:0] {
    TCO_CK_SLOW = 2'h0,
    TCO_CK_MID = 2'h1,
    TCO_CK_FAST = 2'h2,
    TCO_CK_EXT = 2'h3
  } tco_clk_t;

  typedef enum logic [2:0] {
    TCO_ST_STOP = 3'h1,
    TCO_ST_ARMED = 3'h2,
    TCO_ST_RUN = 3'h4
  } tco_state_t;

endpackage : tco_pkg
